// ---- bie_map.vh ----
// Constants for the branch and increment execute block.
// Assumes 12-bit instruction words and 8-bit file registers.
`ifndef BIE_MAP_VH
`define BIE_MAP_VH

// =========================================================
// Opcode fields
`define BIE_BR_OP_HI      11
`define BIE_BR_OP_LO      9
`define BIE_BR_OP         3'h5
`define BIE_BR_LIT_HI     8
`define BIE_FOP_HI        11
`define BIE_FOP_LO        6
`define BIE_INC_OP        6'h0A
`define BIE_INCSZ_OP      6'h0F
`define BIE_DEST_BIT      5
`define BIE_FADDR_HI      4
`define BIE_NOP_WORD      12'h000

// =========================================================
// Program counter and status layout, data constants
`define BIE_PC_UP_HI      10
`define BIE_PC_UP_LO      9
`define BIE_ST_PAGE_HI    6
`define BIE_ST_PAGE_LO    5
`define BIE_ST_ZERO       2
`define BIE_DATA_ONE      8'h01
`define BIE_DATA_ZERO     8'h00
`define BIE_PC_RESET      11'h7FF

`endif

// ---- bie_flush_stage.v ----
// One-cycle flush marker: remembers that the next fetched word is dropped.
// Assumes one instruction per ref_clk cycle from the fetch stage.
`timescale 1ns/1ps
`default_nettype none

module bie_flush_stage
(
  input  wire ref_clk,
  input  wire sys_rst,
  input  wire flush_req,
  output reg  flush_reg
);

  always @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      flush_reg <= 1'b0;
    else
      flush_reg <= flush_req;
  end

endmodule

`default_nettype wire

// ---- bie_exec.v ----
// Execute logic for the unconditional branch, register increment and
// increment-and-skip-if-zero instructions.
// Assumes the register file answers file_rdata combinationally for
// file_addr and that fetch supplies one instruction word per cycle.
`timescale 1ns/1ps
`default_nettype none
`include "bie_map.vh"

module bie_exec
(
  input  wire        ref_clk,
  input  wire        sys_rst,
  input  wire        instr_valid,
  input  wire [11:0] instr_word,
  input  wire [7:0]  status_in,
  input  wire [7:0]  file_rdata,
  output reg  [4:0]  file_addr,
  output reg  [10:0] pc_out,
  output reg         pc_load,
  output reg  [7:0]  file_wdata,
  output reg         file_we,
  output reg  [7:0]  w_acc,
  output reg         zero_flag,
  output reg         zero_we,
  output reg         flush_out,
  output reg         op_done
);

  // =========================================================
  // Decode
  wire        flush_reg;
  wire        live;
  wire [11:0] word;
  wire [2:0]  br_field;
  wire [5:0]  fop_field;
  wire        is_br;
  wire        is_inc;
  wire        is_incsz;
  wire        is_any_inc;
  wire        dest_select;
  wire [8:0]  br_literal;
  wire [1:0]  page_bits;
  wire [7:0]  inc_result;
  wire        res_zero;
  wire        skip_hit;

  // Dropped slot executes as a no-op
  assign live = instr_valid & ~flush_reg;
  assign word = live ? instr_word : `BIE_NOP_WORD;
  assign br_field = word[`BIE_BR_OP_HI:`BIE_BR_OP_LO];
  assign fop_field = word[`BIE_FOP_HI:`BIE_FOP_LO];
  assign is_br = live & (br_field == `BIE_BR_OP);
  assign is_inc = live & (fop_field == `BIE_INC_OP);
  assign is_incsz = live & (fop_field == `BIE_INCSZ_OP);
  assign is_any_inc = is_inc | is_incsz;
  assign dest_select = word[`BIE_DEST_BIT];
  assign br_literal = word[`BIE_BR_LIT_HI:0];
  assign page_bits = status_in[`BIE_ST_PAGE_HI:`BIE_ST_PAGE_LO];
  assign inc_result = file_rdata + `BIE_DATA_ONE;
  assign res_zero = (inc_result == `BIE_DATA_ZERO);
  assign skip_hit = is_incsz & res_zero;

  // =========================================================
  // Register file address
  // Address follows the current word so the read is same-cycle;
  // the only output not taken from a flip-flop, for that reason
  always @*
  begin
    file_addr = word[`BIE_FADDR_HI:0];
  end

  // =========================================================
  // Flush of the prefetched word
  // Unknown opcodes pass as no-ops and never flush
  wire flush_req;
  assign flush_req = is_br | skip_hit;

  bie_flush_stage u_flush
  (
    .ref_clk   (ref_clk),
    .sys_rst   (sys_rst),
    .flush_req (flush_req),
    .flush_reg (flush_reg)
  );

  // =========================================================
  // Next values
  reg [10:0] pc_next;
  reg        pc_load_next;
  reg [7:0]  file_wdata_next;
  reg        file_we_next;
  reg [7:0]  w_acc_next;
  reg        zero_flag_next;
  reg        zero_we_next;
  reg        flush_next;
  reg        done_next;

  // Branch: pc holds its last target until the next branch
  always @*
  begin
    pc_next      = pc_out;
    pc_load_next = is_br;
    if (is_br)
    begin
      pc_next = {page_bits, br_literal};
    end
  end

  // Increments: write data holds, strobe pulses one cycle
  always @*
  begin
    file_wdata_next = file_wdata;
    file_we_next    = 1'h0;
    w_acc_next      = w_acc;
    if (is_any_inc)
    begin
      if (dest_select)
      begin
        file_wdata_next = inc_result;
        file_we_next    = 1'h1;
      end
      else
      begin
        w_acc_next = inc_result;
      end
    end
  end

  // Increment-and-skip never touches the flag
  always @*
  begin
    zero_flag_next = zero_flag;
    zero_we_next   = is_inc;
    if (is_inc)
    begin
      zero_flag_next = res_zero;
    end
  end

  // Pulses for the fetch stage and the sequencer
  always @*
  begin
    flush_next = flush_req;
    done_next  = is_br | is_any_inc;
  end

  // =========================================================
  // Registers, one process per output group
  // Program counter group
  always @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pc_out  <= `BIE_PC_RESET;
      pc_load <= 1'h0;
    end
    else
    begin
      pc_out  <= pc_next;
      pc_load <= pc_load_next;
    end
  end

  // Data write group
  always @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      file_wdata <= `BIE_DATA_ZERO;
      file_we    <= 1'h0;
      w_acc      <= `BIE_DATA_ZERO;
    end
    else
    begin
      file_wdata <= file_wdata_next;
      file_we    <= file_we_next;
      w_acc      <= w_acc_next;
    end
  end

  // Status group
  always @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      zero_flag <= 1'h0;
      zero_we   <= 1'h0;
    end
    else
    begin
      zero_flag <= zero_flag_next;
      zero_we   <= zero_we_next;
    end
  end

  // Sequencing group; fetch must not stall while a flush is pending
  always @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      flush_out <= 1'h0;
      op_done   <= 1'h0;
    end
    else
    begin
      flush_out <= flush_next;
      op_done   <= done_next;
    end
  end

endmodule

`default_nettype wire

// ---- bie_exec_assertions.sv ----
// Port timing checks for bie_exec; a flushed word is never decoded.
`timescale 1ns/1ps
`default_nettype none
module bie_chk (
  input wire logic        ref_clk,
  input wire logic        sys_rst,
  input wire logic        instr_valid,
  input wire logic [11:0] instr_word,
  input wire logic [7:0]  status_in,
  input wire logic [7:0]  file_rdata,
  input wire logic [10:0] pc_out,
  input wire logic        pc_load,
  input wire logic [7:0]  file_wdata,
  input wire logic        file_we,
  input wire logic [7:0]  w_acc,
  input wire logic        zero_flag,
  input wire logic        zero_we,
  input wire logic        flush_out
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  wire tk = instr_valid && !flush_out;
  wire br = tk && instr_word[11:9] == 3'h5;
  wire inc = tk && instr_word[11:6] == 6'h0A;
  wire isz = tk && instr_word[11:6] == 6'h0F;
  wire [7:0] sum = file_rdata + 8'h01;
  sequence s_branch; br ##1 pc_load; endsequence
  a_branch_pc: assert property (s_branch |-> pc_out ==
    {$past(status_in[6:5]), $past(instr_word[8:0])}) else $error("bad pc");
  a_branch_quiet: assert property (br |=> flush_out && !zero_we)
    else $error("branch flags");
  a_inc_wr: assert property ((inc || isz) && instr_word[5] |=>
    file_we && file_wdata == $past(sum)) else $error("bad write");
  a_acc_wr: assert property ((inc || isz) && !instr_word[5] |=>
    !file_we && w_acc == $past(sum)) else $error("bad acc");
  a_inc_zero: assert property (inc |=> zero_we &&
    zero_flag == ($past(sum) == 8'h00)) else $error("bad zero");
  a_isz_flags: assert property (isz |=> !zero_we && $stable(zero_flag))
    else $error("skip touched zero");
  a_skip_flush: assert property (isz |=>
    flush_out == ($past(file_rdata) == 8'hFF)) else $error("bad skip");
  a_drop_word: assert property (flush_out |=> !file_we && !pc_load)
    else $error("dropped word ran");
endmodule
bind bie_exec bie_chk bie_chk_inst (.*);
`default_nettype wire

// ---- bie_rf_model.sv ----
// Register file: same-cycle read, write to last cycle's address.
`timescale 1ns/1ps
`default_nettype none
module bie_rf (
  input  wire logic       ref_clk,
  input  wire logic [4:0] file_addr,
  input  wire logic [7:0] file_wdata,
  input  wire logic       file_we,
  output logic      [7:0] file_rdata
);
  logic [7:0] mem [32];
  logic [4:0] wa_reg;
  initial for (int i = 0; i < 32; i++) mem[i] = 8'hE0 + 8'(i);
  assign file_rdata = mem[file_addr];
  always @(posedge ref_clk)
  begin
    wa_reg <= file_addr;
    if (file_we) mem[wa_reg] <= file_wdata;
  end
endmodule
`default_nettype wire

// ---- tb_top.sv ----
// Bench for bie_exec: table of single ops, then dropped word and reset.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        ref_clk = 0, sys_rst = 1, instr_valid = 0;
  logic [11:0] instr_word = 0;
  logic [7:0]  status_in = 0, file_rdata, file_wdata, w_acc;
  logic [4:0]  file_addr;
  logic [10:0] pc_out, got;
  logic        pc_load, file_we, zero_flag, zero_we, flush_out, op_done;
  int          err_total = 0, tests_run = 0, cyc = 0;
  // Word, status, then result, flush, zero; registers preload E0 + index
  logic [32:0] rows [8] = '{{20'hA5A60, 13'h196A}, {20'h28300, 13'h0390},
    {20'h3FF00, 13'h0002}, {20'h29F00, 13'h0004}, {20'h2BE00, 13'h03FC},
    {20'h2BE00, 13'h0001}, {20'h3C300, 13'h0391}, {20'hA5A20, 13'h096B}};
  bie_exec bie_exec_inst (.*);
  bie_rf bie_rf_inst (.*);
  initial forever #5 ref_clk = ~ref_clk;
  task automatic chk(string n, logic [10:0] e, logic [10:0] g);
    tests_run++;
    if (g !== e)
    begin
      err_total++;
      $display("FAIL %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  always @(posedge ref_clk)
    if (++cyc == 400)
    begin
      err_total++;
      finish_test();
    end
  initial
  begin
    repeat (12) @(negedge ref_clk);
    sys_rst = 0;
    foreach (rows[i])
    begin
      {instr_word, status_in} = rows[i][32:13];
      instr_valid = 1;
      @(negedge ref_clk);
      instr_valid = 0;
      got = instr_word[11:9] == 3'h5 ? pc_out
          : instr_word[5] ? {3'h0, file_wdata} : {3'h0, w_acc};
      chk("done", 11'h1, op_done);
      chk("pc_load", instr_word[11:9] == 3'h5, pc_load);
      chk("result", rows[i][12:2], got);
      chk("flush", rows[i][1], flush_out);
      chk("zero", rows[i][0], zero_flag);
      @(negedge ref_clk);
      $display("row %0d done", i);
    end
    // Word right behind a branch must be dropped
    instr_word = 12'hA5A;
    instr_valid = 1;
    @(negedge ref_clk);
    instr_word = 12'h2BE;
    @(negedge ref_clk);
    chk("drop_we", 11'h0, file_we);
    chk("drop_zwe", 11'h0, zero_we);
    instr_valid = 0;
    @(negedge ref_clk);
    chk("drop_z", 11'h1, zero_flag);
    sys_rst = 1;
    @(negedge ref_clk);
    chk("rst_pc", 11'h7FF, pc_out);
    $display("hand tests done");
    finish_test();
  end
endmodule
`default_nettype wire
